// ---- src/dsa_datapath.sv ----
/*
  Store, constant source, conversion register, scaler and ALU of the
  program-driven signal processor; one instruction per valid clock.
  Assumes program memory presents one instruction per cycle on the same
  clock, and a comparator level from the analog side arriving asynchronously.
*/
`timescale 1ns/1ps
`include "dsa_map.svh"


module dsa_datapath import dsa_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire dsa_instr_t instr_i,
  input wire logic instr_valid_i,
  input wire logic comparator_i,
  input wire logic [`DSA_BUS_ADDR_W-1:0] bus_addr_i,
  input wire logic [`DSA_BUS_DATA_W-1:0] bus_wdata_i,
  input wire logic bus_write_i,
  input wire logic bus_read_i,
  output logic [`DSA_BUS_DATA_W-1:0] bus_rdata_o,
  output logic [`DSA_CONV_W-1:0] dac_o,
  output logic overflow_indicator_pin_n_o,
  output logic overflow_indicator_pin_oe_o
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Address decode; store and conversion checks shared by both ports, constant check source only
  function automatic logic is_store(input logic [`DSA_ADDR_W-1:0] addr);
    is_store = (addr < 6'(`DSA_STORE_WORDS));
  endfunction

  function automatic logic is_const(input logic [`DSA_ADDR_W-1:0] addr);
    is_const = (addr[`DSA_ADDR_W-1:`DSA_ADDR_W-2] == `DSA_CONST_TAG);
  endfunction

  function automatic logic is_conv(input logic [`DSA_ADDR_W-1:0] addr);
    is_conv = (addr == `DSA_CONV_ADDR);
  endfunction

  // Sign extension of a stored word to the ALU width
  function automatic logic [`DSA_EXT_W-1:0] sext(input logic [`DSA_WORD_W-1:0] w);
    sext = {{(`DSA_EXT_W-`DSA_WORD_W){w[`DSA_WORD_W-1]}}, w};
  endfunction

  // A 28-bit value fits the fraction range when its top four bits agree
  function automatic logic out_of_range(input logic [`DSA_EXT_W-1:0] v);
    out_of_range = (v[`DSA_EXT_W-1:`DSA_WORD_W-1] != {(`DSA_EXT_W-`DSA_WORD_W+1){1'b0}}) &&
                   (v[`DSA_EXT_W-1:`DSA_WORD_W-1] != {(`DSA_EXT_W-`DSA_WORD_W+1){1'b1}});
  endfunction

  // Full scale of the given sign: minus one or one less one count
  function automatic logic [`DSA_WORD_W-1:0] full_scale(input logic negative);
    full_scale = negative ? {1'b1, {(`DSA_WORD_W-1){1'b0}}} : {1'b0, {(`DSA_WORD_W-1){1'b1}}};
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [`DSA_WORD_W-1:0] store_reg [0:`DSA_STORE_WORDS-1];
  logic [`DSA_CONV_W-1:0] conv_reg;
  logic [`DSA_CONV_W-1:0] conv_next;
  logic limit_en_reg;
  logic last_ovf_reg;
  logic sticky_ovf_reg;
  logic [`DSA_WORD_W-1:0] result_reg;
  logic [`DSA_BUS_DATA_W-1:0] rdata_reg;
  logic ovf_pin_n_reg;
  logic ovf_pin_oe_reg;
  logic comp_meta_reg;
  logic comp_sync_reg;

  // ----------------------------------------------------------------------
  // Operand fetch
  // ----------------------------------------------------------------------
  logic [`DSA_WORD_W-1:0] conv_word;
  logic [`DSA_WORD_W-1:0] const_word;
  logic [`DSA_WORD_W-1:0] src_store_word;
  logic [`DSA_WORD_W-1:0] dst_store_word;
  logic [`DSA_WORD_W-1:0] src_word;
  logic [`DSA_WORD_W-1:0] dst_word;
  logic [`DSA_EXT_W-1:0] src_scaled;
  logic [`DSA_EXT_W-1:0] dst_ext;

  // Lower bits read as ones, which cancels the converter's offset
  assign conv_word = {conv_reg, `DSA_CONV_FILL};
  // Low address nibble lands in the top nibble: multiples of one eighth
  assign const_word = {instr_i.src_addr[3:0], `DSA_CONST_FILL};
  // Index only inside the store; other addresses get a harmless word 0
  assign src_store_word = store_reg[is_store(instr_i.src_addr) ? instr_i.src_addr : 6'h00];
  assign dst_store_word = store_reg[is_store(instr_i.dst_addr) ? instr_i.dst_addr : 6'h00];

  // Source port: store, conversion register or constant; read only
  assign src_word = is_const(instr_i.src_addr) ? const_word :
                    is_conv(instr_i.src_addr) ? conv_word :
                    is_store(instr_i.src_addr) ? src_store_word :
                    {`DSA_WORD_W{1'b0}};
  // Destination port: constants are not reachable here, they read as zero
  assign dst_word = is_conv(instr_i.dst_addr) ? conv_word :
                    is_store(instr_i.dst_addr) ? dst_store_word :
                    {`DSA_WORD_W{1'b0}};

  // Source always passes the scaler, constants included
  dsa_scaler u_scaler (
    .shift_code_i (instr_i.shift_code),
    .word_i (src_word),
    .scaled_o (src_scaled)
  );

  // Destination enters unscaled, widened only
  assign dst_ext = sext(dst_word);

  // ----------------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------------
  logic [`DSA_EXT_W-1:0] src_abs;
  logic [`DSA_EXT_W-1:0] alu_wide;
  logic src_range_ovf;
  logic alu_ovf;
  logic [`DSA_WORD_W-1:0] alu_result;
  logic cond_bit;
  logic executes;

  // Scaled source stays bounded by four, so negation cannot wrap in 28 bits
  assign src_abs = src_scaled[`DSA_EXT_W-1] ? (~src_scaled + 28'h0000001) : src_scaled;
  // A left shift that flips the sign's sense leaves the range
  assign src_range_ovf = out_of_range(src_scaled);

  // Every operation runs in 28 bits so shifted sources give true results
  always_comb begin
    case (instr_i.alu_op)
      DSA_OP_ADD: alu_wide = dst_ext + src_scaled;
      DSA_OP_SUB: alu_wide = dst_ext - src_scaled;
      DSA_OP_LDA: alu_wide = src_scaled;
      DSA_OP_XOR: alu_wide = dst_ext ^ src_scaled;
      DSA_OP_AND: alu_wide = dst_ext & src_scaled;
      DSA_OP_ABS: alu_wide = src_abs;
      DSA_OP_ABA: alu_wide = dst_ext + src_abs;
      DSA_OP_LIM: alu_wide = sext(full_scale(src_scaled[`DSA_EXT_W-1]));
      default: alu_wide = {`DSA_EXT_W{1'b0}};
    endcase
  end

  // Limit reports overflow only when a plain load would have overflowed
  assign alu_ovf = (instr_i.alu_op == DSA_OP_LIM) ? src_range_ovf : out_of_range(alu_wide);

  // Saturate on the computed sign, or keep the low 25 bits
  assign alu_result = (limit_en_reg && alu_ovf) ? full_scale(alu_wide[`DSA_EXT_W-1]) :
                      alu_wide[`DSA_WORD_W-1:0];

  // Out-of-range selects read as zero, so they turn the operation into a nop
  assign cond_bit = (instr_i.bit_sel < 4'(`DSA_CONV_W)) ? conv_reg[instr_i.bit_sel] : 1'b0;
  assign executes = instr_valid_i && ((instr_i.ana_code != DSA_ANA_COND) || cond_bit);

  // ----------------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------------

  // Comparator comes from the analog side, so two flops before use
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comparator_i;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion register
  // ----------------------------------------------------------------------
  logic sar_start;
  logic sar_step;
  logic sar_bit_ok;
  logic conv_alu_write;
  logic bus_sel_ctrl;
  logic bus_sel_status;
  logic bus_sel_conv;
  logic bus_sel_result;
  logic [`DSA_CONV_W-1:0] sar_stepped;

  assign sar_start = instr_valid_i && (instr_i.ana_code == DSA_ANA_SAR_START);
  assign sar_step = instr_valid_i && (instr_i.ana_code == DSA_ANA_SAR_STEP);
  assign sar_bit_ok = (instr_i.bit_sel < 4'(`DSA_CONV_W));
  assign conv_alu_write = executes && is_conv(instr_i.dst_addr);

  // Step: selected bit keeps the comparator verdict, next lower bit is tried
  always_comb begin
    sar_stepped = conv_reg;
    if (sar_bit_ok) begin
      sar_stepped[instr_i.bit_sel] = comp_sync_reg;
      if (instr_i.bit_sel != 4'h0) begin
        sar_stepped[instr_i.bit_sel - 4'h1] = 1'b1;
      end
    end
  end

  // The ALU write wins over a step in the same cycle, software comes last
  assign conv_next = conv_alu_write ? alu_result[`DSA_WORD_W-1:`DSA_WORD_W-`DSA_CONV_W] :
                     sar_start ? {1'b1, {(`DSA_CONV_W-1){1'b0}}} :
                     sar_step ? sar_stepped :
                     (bus_write_i && bus_sel_conv) ? bus_wdata_i[`DSA_CONV_W-1:0] :
                     conv_reg;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      conv_reg <= `DSA_CONV_RESET;
    end else begin
      conv_reg <= conv_next;
    end
  end

  // Converter inputs follow the register itself, no extra stage
  assign dac_o = conv_reg;

  // ----------------------------------------------------------------------
  // Store write-back
  // ----------------------------------------------------------------------

  // Reads above are combinational, so both ports see the pre-write value
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `DSA_STORE_WORDS; i++) begin
        store_reg[i] <= {`DSA_WORD_W{1'b0}};
      end
    end else if (executes && is_store(instr_i.dst_addr)) begin
      store_reg[instr_i.dst_addr] <= alu_result;
    end
  end

  // ----------------------------------------------------------------------
  // Overflow pin
  // ----------------------------------------------------------------------

  // Registered, so the pin reports the operation of the previous cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ovf_pin_n_reg <= 1'b1;
      ovf_pin_oe_reg <= 1'b0;
    end else begin
      ovf_pin_n_reg <= ~(executes && alu_ovf);
      ovf_pin_oe_reg <= executes && alu_ovf;
    end
  end

  assign overflow_indicator_pin_n_o = ovf_pin_n_reg;
  assign overflow_indicator_pin_oe_o = ovf_pin_oe_reg;

  // ----------------------------------------------------------------------
  // Software register port
  // ----------------------------------------------------------------------
  logic sticky_clear;
  logic [`DSA_BUS_DATA_W-1:0] read_mux;

  assign bus_sel_ctrl = (bus_addr_i == `DSA_OFS_CTRL);
  assign bus_sel_status = (bus_addr_i == `DSA_OFS_STATUS);
  assign bus_sel_conv = (bus_addr_i == `DSA_OFS_CONV);
  assign bus_sel_result = (bus_addr_i == `DSA_OFS_RESULT);
  assign sticky_clear = bus_write_i && bus_sel_status && bus_wdata_i[`DSA_STATUS_STICKY_BIT];

  // Unmapped offsets read as zero
  assign read_mux = bus_sel_ctrl ? {31'h00000000, limit_en_reg} :
                    bus_sel_status ? {30'h00000000, sticky_ovf_reg, last_ovf_reg} :
                    bus_sel_conv ? {23'h000000, conv_reg} :
                    bus_sel_result ? {7'h00, result_reg} :
                    32'h00000000;

  // Control register steers saturation
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      limit_en_reg <= `DSA_CTRL_RESET;
    end else if (bus_write_i && bus_sel_ctrl) begin
      limit_en_reg <= bus_wdata_i[`DSA_CTRL_LIMIT_BIT];
    end
  end

  // A new overflow beats a clear arriving in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      last_ovf_reg <= 1'b0;
      sticky_ovf_reg <= 1'b0;
    end else begin
      if (executes) begin
        last_ovf_reg <= alu_ovf;
      end
      sticky_ovf_reg <= (executes && alu_ovf) || (sticky_ovf_reg && !sticky_clear);
    end
  end

  // Last value written back, for software to inspect
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      result_reg <= {`DSA_WORD_W{1'b0}};
    end else if (executes && (is_store(instr_i.dst_addr) || is_conv(instr_i.dst_addr))) begin
      result_reg <= alu_result;
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= bus_read_i ? read_mux : 32'h00000000;
    end
  end

  assign bus_rdata_o = rdata_reg;

endmodule

// ---- src/dsa_map.svh ----
/*
  Constants of the scaler/ALU datapath: address map of the operand space,
  field widths, software register offsets, field positions and reset values.
  Assumes it is included by the package, the datapath modules and the checker only.
*/
`ifndef DSA_MAP_SVH
`define DSA_MAP_SVH

// ----------------------------------------------------------------------
// Word format and operand address space
// ----------------------------------------------------------------------
`define DSA_WORD_W 25
`define DSA_EXT_W 28
`define DSA_ADDR_W 6
`define DSA_SHIFT_W 4
`define DSA_OP_W 3
`define DSA_STORE_WORDS 40
`define DSA_CONV_ADDR 6'h28
`define DSA_CONST_TAG 2'h3
`define DSA_CONV_W 9
`define DSA_CONV_FILL 16'hffff
`define DSA_CONST_FILL 21'h000000
`define DSA_BITSEL_W 4

// ----------------------------------------------------------------------
// Scaler codes
// ----------------------------------------------------------------------
`define DSA_SHIFT_LEFT_TWO 4'he
`define DSA_SHIFT_LEFT_ONE 4'hd
`define DSA_SHIFT_NONE 4'hf
`define DSA_SHIFT_RIGHT_THIRTEEN 4'hc

// ----------------------------------------------------------------------
// Software register port
// ----------------------------------------------------------------------
`define DSA_BUS_ADDR_W 8
`define DSA_BUS_DATA_W 32
`define DSA_OFS_CTRL 8'h00
`define DSA_OFS_STATUS 8'h04
`define DSA_OFS_CONV 8'h08
`define DSA_OFS_RESULT 8'h0c
`define DSA_CTRL_LIMIT_BIT 0
`define DSA_STATUS_LAST_BIT 0
`define DSA_STATUS_STICKY_BIT 1
`define DSA_CTRL_RESET 1'h0
`define DSA_CONV_RESET 9'h000

`endif

// ---- src/dsa_pkg.sv ----
/*
  Types of the scaler/ALU datapath: instruction fields, operation and
  analog-field codes. Assumes dsa_map.svh is on the include path.
*/
`include "dsa_map.svh"

package dsa_pkg;

  // ----------------------------------------------------------------------
  // Operation and analog-field codes
  // ----------------------------------------------------------------------
  typedef enum logic [`DSA_OP_W-1:0] {
    DSA_OP_ADD = 3'h0,
    DSA_OP_SUB = 3'h1,
    DSA_OP_LDA = 3'h2,
    DSA_OP_XOR = 3'h3,
    DSA_OP_AND = 3'h4,
    DSA_OP_ABS = 3'h5,
    DSA_OP_ABA = 3'h6,
    DSA_OP_LIM = 3'h7
  } dsa_alu_op_t;

  typedef enum logic [1:0] {
    DSA_ANA_NOP = 2'h0,
    DSA_ANA_COND = 2'h1,
    DSA_ANA_SAR_START = 2'h2,
    DSA_ANA_SAR_STEP = 2'h3
  } dsa_ana_t;

  // ----------------------------------------------------------------------
  // One instruction as it arrives from program memory
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [`DSA_ADDR_W-1:0] src_addr;
    logic [`DSA_ADDR_W-1:0] dst_addr;
    logic [`DSA_SHIFT_W-1:0] shift_code;
    dsa_alu_op_t alu_op;
    dsa_ana_t ana_code;
    logic [`DSA_BITSEL_W-1:0] bit_sel;
  } dsa_instr_t;

endpackage

// ---- src/dsa_scaler.sv ----
/*
  Barrel scaler between the source port and the ALU.
  Assumes a 25-bit two's complement source word; output is 28 bits wide
  so that left shifts keep their overflowing magnitude.
*/
`timescale 1ns/1ps
`include "dsa_map.svh"

module dsa_scaler import dsa_pkg::*; (
  input wire logic [`DSA_SHIFT_W-1:0] shift_code_i,
  input wire logic [`DSA_WORD_W-1:0] word_i,
  output logic [`DSA_EXT_W-1:0] scaled_o
);

  // ----------------------------------------------------------------------
  // Decode and shift
  // ----------------------------------------------------------------------
  logic [`DSA_EXT_W-1:0] ext_word;
  logic [3:0] right_amt;
  logic do_left_two;
  logic do_left_one;
  logic do_none;

  // Sign extension first, so right shifts replicate the sign  
  assign ext_word = {{(`DSA_EXT_W-`DSA_WORD_W){word_i[`DSA_WORD_W-1]}}, word_i};
  assign do_left_two = (shift_code_i == `DSA_SHIFT_LEFT_TWO);
  assign do_left_one = (shift_code_i == `DSA_SHIFT_LEFT_ONE);
  assign do_none = (shift_code_i == `DSA_SHIFT_NONE);
  // Codes 0..12 shift right by code plus one, at most thirteen
  assign right_amt = shift_code_i + 4'h1;

  // Left fills zeros at the bottom, right fills the sign at the top
  assign scaled_o = do_left_two ? (ext_word << 2) :
                    do_left_one ? (ext_word << 1) :
                    do_none ? ext_word :
                    $unsigned($signed(ext_word) >>> right_amt);

endmodule

// ---- testbench/dsa_datapath_chk_sva.sv ----
/*
  Concurrent checks on the datapath's top-level ports.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "dsa_map.svh"

module dsa_datapath_chk import dsa_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire dsa_instr_t instr_i,
  input wire logic instr_valid_i,
  input wire logic bus_write_i,
  input wire logic bus_read_i,
  input wire logic [`DSA_BUS_DATA_W-1:0] bus_rdata_o,
  input wire logic [`DSA_CONV_W-1:0] dac_o,
  input wire logic overflow_indicator_pin_n_o,
  input wire logic overflow_indicator_pin_oe_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  // ----------------------------------------------------------------------
  // Instruction shapes used by several checks
  // ----------------------------------------------------------------------
  sequence s_lda_const;
    instr_valid_i && instr_i.alu_op == DSA_OP_LDA && instr_i.src_addr[5:4] == 2'h3 &&
      instr_i.ana_code == DSA_ANA_NOP;
  endsequence
  // Bus write into the conversion register in the same cycle would win nothing, so keep it apart
  sequence s_sar(dsa_ana_t c);
    instr_valid_i && instr_i.ana_code == c && instr_i.dst_addr != `DSA_CONV_ADDR && !bus_write_i;
  endsequence

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_oe_mirrors_pin: assert property (overflow_indicator_pin_oe_o == !overflow_indicator_pin_n_o)
    else $error("overflow enable does not mirror the pin");
  a_pin_needs_op: assert property (!overflow_indicator_pin_n_o |-> $past(instr_valid_i))
    else $error("overflow pin low without an executed instruction");
  a_rdata_one_cycle: assert property (!$past(bus_read_i) |-> bus_rdata_o == 32'h0)
    else $error("read data present outside the answer cycle");
  a_dac_holds: assert property (!instr_valid_i && !bus_write_i |=> $stable(dac_o))
    else $error("converter output moved without a cause");
  a_const_to_conv: assert property (s_lda_const ##0 instr_i.shift_code == `DSA_SHIFT_NONE &&
      instr_i.dst_addr == `DSA_CONV_ADDR |=> dac_o == {$past(instr_i.src_addr[3:0]), 5'h00})
    else $error("constant not placed in the top bits");
  a_left_one_ovf: assert property (s_lda_const ##0 instr_i.shift_code == `DSA_SHIFT_LEFT_ONE
      |=> overflow_indicator_pin_n_o == ($past(instr_i.src_addr[3]) == $past(instr_i.src_addr[2])))
    else $error("left shift overflow flagged wrongly");
  a_sar_start: assert property (s_sar(DSA_ANA_SAR_START) |=> dac_o == 9'h100)
    else $error("approximation start value wrong");
  a_sar_step: assert property (s_sar(DSA_ANA_SAR_STEP) ##0 instr_i.bit_sel inside {[1:8]}
      |=> dac_o[$past(instr_i.bit_sel) - 1])
    else $error("approximation trial bit not set");
  a_cond_skip: assert property (instr_valid_i && instr_i.ana_code == DSA_ANA_COND && instr_i.bit_sel > 4'h8
      |=> overflow_indicator_pin_n_o)
    else $error("skipped conditional instruction flagged overflow");
endmodule

// ---- testbench/dsa_prog_model.sv ----
/*
  Program memory stand-in: presents one instruction word per issue call.
  Assumes the datapath takes the word at the rising edge after it is set.
*/
`timescale 1ns/1ps

module dsa_prog_model import dsa_pkg::*; (
  input wire logic sys_clk_i,
  output dsa_instr_t instr_o,
  output logic instr_valid_o
);
  // Idle until the first fetch
  initial begin
    instr_o = '0;
    instr_valid_o = 1'b0;
  end

  // One fetch; fields are scrambled afterwards so stale words are never reused by luck
  task automatic issue(input logic [5:0] s, d, input logic [3:0] sh, input dsa_alu_op_t op,
                       input dsa_ana_t ana, input logic [3:0] b);
    @(posedge sys_clk_i);
    instr_o <= '{s, d, sh, op, ana, b};
    instr_valid_o <= 1'b1;
    @(posedge sys_clk_i);
    instr_valid_o <= 1'b0;
    instr_o <= dsa_instr_t'(~instr_o);
  endtask
endmodule

// ---- testbench/testbench.sv ----
/*
  Self-checking bench: instructions through the program model, registers
  through the strobe port. Assumes the single 25 MHz clock.
*/
`timescale 1ns/1ps

module testbench import dsa_pkg::*; ;
  logic sys_clk_i, reset_i, comparator_i, bus_write_i, bus_read_i, instr_valid_i;
  logic [7:0] bus_addr_i;
  logic [31:0] bus_wdata_i, bus_rdata_o, rv;
  logic [8:0] dac_o;
  logic overflow_indicator_pin_n_o, overflow_indicator_pin_oe_o;
  logic [5:0] s;
  dsa_instr_t instr_i;
  int bad_count, n_tests;

  dsa_prog_model u_prog (.sys_clk_i, .instr_o(instr_i), .instr_valid_o(instr_valid_i));
  dsa_datapath u_dut (.sys_clk_i, .reset_i, .instr_i, .instr_valid_i, .comparator_i, .bus_addr_i,
    .bus_wdata_i, .bus_write_i, .bus_read_i, .bus_rdata_o, .dac_o, .overflow_indicator_pin_n_o,
    .overflow_indicator_pin_oe_o);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_write_i <= 1'b1;
    @(posedge sys_clk_i);
    bus_write_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    bus_addr_i <= a;
    bus_read_i <= 1'b1;
    @(posedge sys_clk_i);
    bus_read_i <= 1'b0;
    #1 d = bus_rdata_o;
  endtask
  task automatic step(input logic [5:0] s, d, input logic [3:0] sh, input dsa_alu_op_t op,
                      input dsa_ana_t ana, input logic [3:0] b, input logic [24:0] exp, input logic n);
    u_prog.issue(s, d, sh, op, ana, b);
    #1 check(overflow_indicator_pin_n_o, n);
    rd(8'h0c, rv);
    check(rv, {7'h00, exp});
  endtask
  // Independent scaler model: 28-bit arithmetic, low 25 bits kept
  function automatic logic [24:0] scl(input logic [24:0] v, input logic [3:0] c);
    logic signed [27:0] x;
    x = {{3{v[24]}}, v};
    if (c == 4'he) x = x <<< 2;
    else if (c == 4'hd) x = x <<< 1;
    else if (c != 4'hf) x = x >>> (c + 1);
    return x[24:0];
  endfunction

  // ----------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    conclude();
  end
  initial begin
    {reset_i, comparator_i, bus_write_i, bus_read_i, bus_addr_i, bus_wdata_i} = {4'b1100, 40'h0};
    bad_count = 0;
    n_tests = 0;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(i * 4, rv);
      check(rv, 32'h0);
    end
    check({dac_o, overflow_indicator_pin_n_o, overflow_indicator_pin_oe_o}, 11'h002);
    $display("test reset done");
    for (int k = 0; k < 16; k++)
      step(6'h30 | k[5:0], k[5:0], 4'hf, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, {k[3:0], 21'h0}, 1'b1);
    for (int k = 0; k < 32; k++) begin
      s = k[4] ? 6'h3c : 6'h34;
      step(s, 6'h01, k[3:0], DSA_OP_LDA, DSA_ANA_NOP, 4'h0, scl({s[3:0], 21'h0}, k[3:0]),
           !(k[3:0] == 4'he || (k[3:0] == 4'hd && !k[4])));
    end
    $display("test constants and scaler done");
    step(6'h34, 6'h02, 4'hf, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, 25'h0800000, 1'b1);
    step(6'h32, 6'h02, 4'hf, DSA_OP_ADD, DSA_ANA_NOP, 4'h0, 25'h0c00000, 1'b1);
    step(6'h31, 6'h02, 4'hf, DSA_OP_SUB, DSA_ANA_NOP, 4'h0, 25'h0a00000, 1'b1);
    step(6'h02, 6'h02, 4'hf, DSA_OP_ADD, DSA_ANA_NOP, 4'h0, 25'h1400000, 1'b0);
    wr(8'h00, 32'h1);
    step(6'h3c, 6'h03, 4'he, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, 25'h1000000, 1'b0);
    step(6'h34, 6'h03, 4'he, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, 25'h0ffffff, 1'b0);
    rd(8'h04, rv);
    check(rv, 32'h3);
    wr(8'h04, 32'h2);
    step(6'h3c, 6'h04, 4'h0, DSA_OP_ABS, DSA_ANA_NOP, 4'h0, 25'h0400000, 1'b1);
    rd(8'h04, rv);
    check(rv, 32'h0);
    step(6'h3c, 6'h04, 4'hf, DSA_OP_ABA, DSA_ANA_NOP, 4'h0, 25'h0c00000, 1'b1);
    step(6'h3c, 6'h04, 4'hf, DSA_OP_XOR, DSA_ANA_NOP, 4'h0, 25'h1400000, 1'b1);
    step(6'h3c, 6'h04, 4'hf, DSA_OP_AND, DSA_ANA_NOP, 4'h0, 25'h1000000, 1'b1);
    step(6'h34, 6'h04, 4'hf, DSA_OP_LIM, DSA_ANA_NOP, 4'h0, 25'h0ffffff, 1'b1);
    $display("test arithmetic done");
    step(6'h37, 6'h28, 4'hf, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, 25'h0e00000, 1'b1);
    check(dac_o, 9'h0e0);
    step(6'h28, 6'h05, 4'hf, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, 25'h0e0ffff, 1'b1);
    wr(8'h08, 32'h1a5);
    rd(8'h08, rv);
    check(rv, 32'h1a5);
    check(dac_o, 9'h1a5);
    step(6'h30, 6'h06, 4'hf, DSA_OP_LDA, DSA_ANA_SAR_START, 4'h0, 25'h0, 1'b1);
    check(dac_o, 9'h100);
    step(6'h30, 6'h06, 4'hf, DSA_OP_LDA, DSA_ANA_SAR_STEP, 4'h8, 25'h0, 1'b1);
    check(dac_o, 9'h180);
    @(posedge sys_clk_i);
    comparator_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    step(6'h30, 6'h06, 4'hf, DSA_OP_LDA, DSA_ANA_SAR_STEP, 4'h7, 25'h0, 1'b1);
    check(dac_o, 9'h140);
    step(6'h34, 6'h07, 4'hf, DSA_OP_LDA, DSA_ANA_COND, 4'h6, 25'h0800000, 1'b1);
    step(6'h3c, 6'h07, 4'hf, DSA_OP_LDA, DSA_ANA_COND, 4'h5, 25'h0800000, 1'b1);
    step(6'h34, 6'h07, 4'he, DSA_OP_LDA, DSA_ANA_COND, 4'hf, 25'h0800000, 1'b1);
    step(6'h32, 6'h29, 4'hf, DSA_OP_LDA, DSA_ANA_NOP, 4'h0, 25'h0800000, 1'b1);
    $display("test conversion register done");
    conclude();
  end
endmodule

bind dsa_datapath dsa_datapath_chk u_chk (.sys_clk_i, .reset_i, .instr_i, .instr_valid_i, .bus_write_i,
  .bus_read_i, .bus_rdata_o, .dac_o, .overflow_indicator_pin_n_o, .overflow_indicator_pin_oe_o);
